/* rtl/psrcd_pkg.sv */
package psrcd_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned LANES = 4;
  localparam int unsigned LANE_W = 9;
  localparam int unsigned DATA_W = LANES * LANE_W;
  localparam int unsigned DEPTH = 1 << ADDR_W;
  localparam int unsigned BURST_LSB_W = 2;
  localparam int unsigned SLEEP_CYCLES = 2;
  localparam logic [1:0] SLEEP_CNT_RST = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
  localparam logic [LANES-1:0] LANE_NONE = 4'hf;
  typedef enum logic [3:0] {
    PSRCD_IDLE  = 4'b0001,
    PSRCD_READ  = 4'b0010,
    PSRCD_WRITE = 4'b0100,
    PSRCD_ABORT = 4'b1000
  } psrcd_cyc_t;
endpackage : psrcd_pkg

/* rtl/psrcd_burst_next.sv */
`timescale 1ns/1ps
`default_nettype none
module psrcd_burst_next
  import psrcd_pkg::*;
(
  input wire logic [ADDR_W-1:0] cur_addr, // current burst address
  input wire logic [BURST_LSB_W-1:0] start_lsb, // low bits at burst start
  input wire logic interleave, // high selects interleaved order
  output logic [ADDR_W-1:0] next_addr // next burst address
);
  wire [BURST_LSB_W-1:0] beat = cur_addr[BURST_LSB_W-1:0] ^ start_lsb;
  wire [BURST_LSB_W-1:0] lin = cur_addr[BURST_LSB_W-1:0] + 2'h1;
  wire [BURST_LSB_W-1:0] inter = start_lsb ^ (beat + 2'h1);
  // only the two low bits count, so both orders wrap in four beats
  assign next_addr = {cur_addr[ADDR_W-1:BURST_LSB_W], interleave ? inter : lin};
endmodule : psrcd_burst_next
`default_nettype wire

/* rtl/psrcd_core.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - new access needs qualify, awake, load, all enables
// - load with write strobe high reads
// - advance continues burst ignoring enables, write strobe
// - read with output enable high stays floating
// - dummy read continuation advances, outputs float
// - load, write strobe low, lane selected writes
// - write continuation writes lanes selected that beat
// - write start with no lanes aborts
// - aborted write beat still advances address
// - qualify high ignores edge, holds state while awake
// - any write cycle floats all data pins
// - output enable asynchronous, masked during writes
// - power up deselected, pins floating
// - write strobe high means read
// - each selected lane writes its byte, parity
// - mode selects linear or interleaved burst
// - write data captured two edges after address
// - sleep entry immediate, exit takes two cycles
module psrcd_core
  import psrcd_pkg::*;
(
  input wire logic REF_CLK, // clock
  input wire logic RST_N, // async reset, power-up model
  input wire logic [ADDR_W-1:0] ADDR, // external address
  input wire logic CE1_N, // chip enable 1, low active
  input wire logic CE2, // chip enable 2, high active
  input wire logic CE3_N, // chip enable 3, low active
  input wire logic ADVANCE_OR_LOAD_STROBE, // high advances, low loads
  input wire logic WE_N, // write strobe, low active
  input wire logic [LANES-1:0] BYTE_LANE_WRITE_SELECT_N, // lane selects
  input wire logic OE_N, // output enable, asynchronous
  input wire logic CLOCK_QUALIFY_N, // clock enable, low active
  input wire logic SLEEP_REQUEST, // sleep input
  input wire logic BURST_ORDER, // high interleaved
  input wire logic [DATA_W-1:0] DQ_IN, // data and parity from pins
  output logic [DATA_W-1:0] DQ_OUT, // data and parity to pins
  output logic DQ_OE, // high while driving pins
  output logic ASLEEP // sleep reached
);
  import psrcd_pkg::*;

  // one store per lane, so each lane process owns its own array
  wire [DATA_W-1:0] rd_word;
  psrcd_cyc_t stage1, stage2;
  logic [ADDR_W-1:0] addr1, addr2;
  logic [LANES-1:0] lanes1, lanes2;
  logic [BURST_LSB_W-1:0] start_lsb;
  logic burst_write;
  logic [DATA_W-1:0] rd_data;
  logic rd_valid;
  logic [1:0] sleep_cnt;
  logic [ADDR_W-1:0] next_addr;

  wire awake = !SLEEP_REQUEST && sleep_cnt == SLEEP_CNT_RST;
  wire run = awake && !CLOCK_QUALIFY_N;
  wire selected = !CE1_N && CE2 && !CE3_N;
  wire load = run && !ADVANCE_OR_LOAD_STROBE;
  wire advance = run && ADVANCE_OR_LOAD_STROBE && stage1 != PSRCD_IDLE;
  wire any_lane = BYTE_LANE_WRITE_SELECT_N != LANE_NONE;
  // write type is latched at load; continuation uses the latched kind
  wire is_write = load ? !WE_N : burst_write;
  psrcd_cyc_t next_stage1;
  assign next_stage1 =
    (load && !selected) ? PSRCD_IDLE :
    !(load || advance) ? PSRCD_IDLE :
    !is_write ? PSRCD_READ :
    any_lane ? PSRCD_WRITE : PSRCD_ABORT;

  psrcd_burst_next u_next (
    .cur_addr(addr1),
    .start_lsb(start_lsb),
    .interleave(BURST_ORDER),
    .next_addr(next_addr)
  );

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sleep_cnt <= SLEEP_CNT_RST;
    end else if (SLEEP_REQUEST) begin
      sleep_cnt <= 2'(SLEEP_CYCLES);
    end else if (sleep_cnt != SLEEP_CNT_RST) begin
      sleep_cnt <= sleep_cnt - 2'h1;
    end
  end

  // address stage then data stage; a stall freezes both
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      stage1 <= PSRCD_IDLE;
      stage2 <= PSRCD_IDLE;
      addr1 <= ADDR_RST;
      addr2 <= ADDR_RST;
      lanes1 <= LANE_NONE;
      lanes2 <= LANE_NONE;
      start_lsb <= 2'h0;
      burst_write <= 1'b0;
    end else if (!awake) begin
      // pending accesses are dropped on entering sleep
      stage1 <= PSRCD_IDLE;
      stage2 <= PSRCD_IDLE;
    end else if (run) begin
      stage1 <= next_stage1;
      stage2 <= stage1;
      addr2 <= addr1;
      lanes2 <= lanes1;
      lanes1 <= BYTE_LANE_WRITE_SELECT_N;
      if (load) begin
        addr1 <= ADDR;
        start_lsb <= ADDR[BURST_LSB_W-1:0];
        burst_write <= !WE_N;
      end else if (advance) begin
        addr1 <= next_addr;
      end
    end
  end

  // lane writes at the edge two after the address edge
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      logic [LANE_W-1:0] lane_mem [DEPTH];
      always_ff @(posedge REF_CLK) begin
        if (run && stage2 == PSRCD_WRITE && !lanes2[g]) begin
          lane_mem[addr2] <= DQ_IN[g*LANE_W +: LANE_W];
        end
      end
      assign rd_word[g*LANE_W +: LANE_W] = lane_mem[addr1];
    end
  endgenerate

  // read data registered one edge after the address edge
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rd_data <= '0;
      rd_valid <= 1'b0;
    end else if (!awake) begin
      rd_valid <= 1'b0;
    end else if (run) begin
      rd_valid <= stage1 == PSRCD_READ;
      rd_data <= rd_word;
    end
  end

  assign DQ_OUT = rd_data;
  // oe not registered; writes and aborts never drive
  assign DQ_OE = rd_valid && !OE_N && awake;
  assign ASLEEP = !awake;
endmodule : psrcd_core
`default_nettype wire

/* verif/psrcd_core_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module psrcd_core_sva (
  input wire logic REF_CLK, // clock
  input wire logic RST_N, // reset
  input wire logic ADVANCE_OR_LOAD_STROBE, // load
  input wire logic WE_N, // write
  input wire logic OE_N, // enable
  input wire logic CLOCK_QUALIFY_N, // stall
  input wire logic SLEEP_REQUEST, // sleep
  input wire logic [psrcd_pkg::DATA_W-1:0] DQ_OUT, // data
  input wire logic DQ_OE, // drive
  input wire logic ASLEEP // asleep
);
  wire awake = !SLEEP_REQUEST && !ASLEEP;
  wire run = !CLOCK_QUALIFY_N && awake;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  // a write slot reaches the output stage one enabled edge after its load
  sequence s_wr; run && !ADVANCE_OR_LOAD_STROBE && !WE_N ##1 run; endsequence
  a_oe_mask: assert property (OE_N |-> !DQ_OE) else $error("oe");
  a_sleep_float: assert property (SLEEP_REQUEST |-> !DQ_OE) else $error("zz");
  a_sleep_flag: assert property (SLEEP_REQUEST |-> ASLEEP) else $error("flag");
  a_wake_hold: assert property ($fell(SLEEP_REQUEST) |-> ASLEEP) else $error("wake");
  a_stall_data: assert property (CLOCK_QUALIFY_N && awake |=> $stable(DQ_OUT)) else $error("st");
  a_stall_drive: assert property (CLOCK_QUALIFY_N && awake && !OE_N ##1 !OE_N && awake
    |-> $stable(DQ_OE)) else $error("sd");
  a_write_float: assert property (s_wr |=> !DQ_OE) else $error("wr");
  a_reset_float: assert property ($rose(RST_N) |-> !DQ_OE) else $error("rst");
endmodule : psrcd_core_sva
bind psrcd_core psrcd_core_sva chk_i (.REF_CLK(REF_CLK), .RST_N(RST_N), .WE_N(WE_N),
  .ADVANCE_OR_LOAD_STROBE(ADVANCE_OR_LOAD_STROBE), .OE_N(OE_N), .DQ_OUT(DQ_OUT),
  .CLOCK_QUALIFY_N(CLOCK_QUALIFY_N), .SLEEP_REQUEST(SLEEP_REQUEST), .DQ_OE(DQ_OE), .ASLEEP(ASLEEP));
`default_nettype wire

/* verif/psrcd_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module psrcd_ctrl_model (
  input wire logic clk, // clock
  input wire logic dev_oe, // device drives
  input wire logic [psrcd_pkg::DATA_W-1:0] wdata, // beat data
  output logic [psrcd_pkg::DATA_W-1:0] dq // to device
);
  import psrcd_pkg::*;
  initial dq = '0;
  // toggles while not presenting, so stale data never passes for a capture
  always @(posedge clk) dq <= dev_oe ? ~dq : wdata;
endmodule : psrcd_ctrl_model
`default_nettype wire

/* verif/pipelined_sram_cycle_decode_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module pipelined_sram_cycle_decode_tb_top;
  import psrcd_pkg::*;
  typedef logic [DATA_W-1:0] psrcd_word_t;
  typedef struct {logic ld, we, ce; logic [3:0] bw; psrcd_word_t wd; logic oe; psrcd_word_t ex;}
    psrcd_row_t;
  localparam psrcd_word_t B = 36'h123456789, C = 36'hfffffffff, M = 36'hff803fe00;
  logic clk = 0, rst_n = 0, adv = 0, we_n = 1, ce = 0, oe_n = 0, cq_n = 0, slp = 0, dq_oe, asleep;
  logic [3:0] bw = 4'hf;
  logic [ADDR_W-1:0] addr = 16'h0020;
  logic mode = 0;
  psrcd_word_t wd = '0, dq_in, dq_out;
  int num_errors = 0, checks_done = 0, cyc = 0;
  // burst write, aborted beat, lanes 1 and 3 rewritten, then a two-beat read back
  psrcd_row_t rows [11] = '{'{0, 0, 1, 0, 0, 0, 0}, '{1, 0, 1, 0, 0, 0, 0}, '{1, 0, 1, 15, B, 0, 0},
    '{0, 0, 1, 5, C, 0, 0}, '{0, 1, 0, 15, C, 0, 0}, '{0, 1, 0, 15, 0, 0, 0}, '{0, 1, 1, 15, 0, 0, 0},
    '{1, 1, 1, 15, 0, 0, 0}, '{0, 1, 0, 15, 0, 1, M}, '{1, 1, 0, 15, 0, 1, B}, '{0, 1, 0, 15, 0, 0, 0}};
  psrcd_ctrl_model ctrl (.clk(clk), .dev_oe(dq_oe), .wdata(wd), .dq(dq_in));
  psrcd_core uut (.REF_CLK(clk), .RST_N(rst_n), .ADDR(addr), .CE1_N(!ce), .CE2(ce),
    .CE3_N(!ce), .ADVANCE_OR_LOAD_STROBE(adv), .WE_N(we_n), .BYTE_LANE_WRITE_SELECT_N(bw),
    .OE_N(oe_n), .CLOCK_QUALIFY_N(cq_n), .SLEEP_REQUEST(slp), .BURST_ORDER(mode), .DQ_IN(dq_in),
    .DQ_OUT(dq_out), .DQ_OE(dq_oe), .ASLEEP(asleep));
  initial forever #10 clk = ~clk;
  task automatic chk(input psrcd_word_t seen, input psrcd_word_t exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    if (num_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 200) begin
      num_errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1;
    #1 chk(dq_oe, 0);
    foreach (rows[i]) begin
      @(posedge clk);
      {adv, we_n, ce, bw, wd} <= {rows[i].ld, rows[i].we, rows[i].ce, rows[i].bw, rows[i].wd};
      #1 chk(dq_oe, rows[i].oe);
      if (rows[i].oe) chk(dq_out, rows[i].ex);
    end
    @(posedge clk) {adv, we_n, ce} <= 3'b011;
    @(posedge clk) {ce, cq_n} <= 2'b01;
    repeat (3) @(posedge clk);
    cq_n <= 0;
    #1 chk(dq_oe, 0);
    @(posedge clk) cq_n <= 1;
    @(posedge clk) oe_n <= 1;
    #1 chk(dq_oe, 0);
    @(posedge clk) oe_n <= 0;
    #1 chk(dq_out, M);
    @(posedge clk) {cq_n, slp} <= 2'b01;
    @(posedge clk) #1 chk(asleep & ~dq_oe, 1);
    repeat (3) @(posedge clk);
    slp <= 0;
    @(posedge clk) #1 chk(asleep, 1);
    repeat (3) @(posedge clk);
    #1 chk(asleep, 0);
    // interleaved burst from low bits 01 goes back to 00, linear would go on to 10
    @(posedge clk) {addr[0], mode, adv, ce} <= 4'b1101;
    @(posedge clk) {adv, ce} <= 2'b10;
    @(posedge clk) adv <= 0;
    #1 chk(dq_out, B);
    @(posedge clk) #1 chk(dq_out, M);
    report_and_stop();
  end
endmodule : pipelined_sram_cycle_decode_tb_top
`default_nettype wire
